// ### logic/icu_top.sv
// Input capture unit with its mode control register, APB slave.
// Assumes the timer count arrives on sys_clk_i from synchronous logic.
// What this block does
// [R1] Control bits 7-6 read zero; bits 5-0 read/write, reset to zero.
// [R2] Bits 5-4 hold duty low bits; unused in capture and compare.
// [R3] Mode zero disables the unit and resets its internal state.
// [R4] Each qualifying event copies the 16-bit timer into the capture pair.
// [R5] Events: every falling, every rising, every 4th or 16th rising edge.
// [R6] Each capture sets the event flag; only software clears it.
// [R7] A new capture overwrites an unread earlier value.
// [R8] Software should make the capture pin an input.
// [R9] With pin as output, a port write can make a capture edge.
// [R10] Location select picks port bit 0 or 3 and its direction bit.
// [R11] Timer must be in timer or synchronised counter mode.
// [R12] Mode change may raise a false flag; software clears it.
// [R13] Prescaler clears when off or not in capture mode.
// [R14] Switching prescaler directly keeps the count and may flag.
// [R15] Software turns unit off before loading a new prescaler.
// [R16] Software-interrupt compare match only sets the flag.
// [R17] Special event match resets timer, starts conversion, no overflow flag.
// [R18] Divided modes count rising edges, capture on 4th/16th, restart.
`timescale 1ns/1ps
`default_nettype none
module icu_top
  import icu_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TIMER_W-1:0] first_timer_count_i,
  input wire logic unit_pin_location_select_i,
  input wire logic port_b0_pin_i,
  input wire logic port_b3_pin_i,
  output logic unit_pin_o,
  output logic unit_pin_oe_o,
  output logic first_timer_reset_o,
  output logic convert_start_o,
  output logic irq_o
);
  if (TIMER_W != 16) begin : g_bad_width
    $error("TIMER_W must be 16");
  end

  logic [ICU_CTRL_W-1:0] mode_ctrl;
  logic [TIMER_W-1:0] capture_value_pair;
  logic [ICU_ST_W-1:0] status;
  logic [ICU_ST_W-1:0] mask;
  logic [ICU_PIN_W-1:0] pin_ctrl;
  logic [3:0] presc;
  logic rise;
  logic fall;
  logic cap_event;
  logic cmp_match;
  logic pin_level;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [ICU_ST_W-1:0] wdat_st;

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m[3:2] == ICU_M_CAP_FALL[3:2]);
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m[3:2] == ICU_M_CMP_SET[3:2]);
  endfunction

  wire logic [3:0] mode = mode_ctrl[ICU_MODE_MSB:ICU_MODE_LSB];

  // APB: zero wait states, word index from byte address
  // Read data loads in setup so it stands at the access edge
  assign idx = paddr[9:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign wdat_st = pwdata[ICU_ST_W-1:0];

  always_comb begin
    case (idx)
      ICU_IDX_MODE_CTRL, ICU_IDX_CAP_LOW, ICU_IDX_CAP_HIGH,
      ICU_IDX_STATUS, ICU_IDX_MASK, ICU_IDX_PIN_CTRL: pslverr = 1'b0;
      default: pslverr = psel & penable;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (idx)
        // Upper two bits not implemented
        ICU_IDX_MODE_CTRL: prdata <= {26'h0, mode_ctrl}; // [R1]
        ICU_IDX_CAP_LOW: prdata <= {24'h0, capture_value_pair[7:0]};
        ICU_IDX_CAP_HIGH: prdata <= {24'h0, capture_value_pair[15:8]};
        ICU_IDX_STATUS: prdata <= {30'h0, status};
        ICU_IDX_MASK: prdata <= {30'h0, mask};
        ICU_IDX_PIN_CTRL: prdata <= {29'h0, pin_ctrl};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ctrl <= ICU_MODE_CTRL_RESET; // [R1]
    end else if (wr_en && idx == ICU_IDX_MODE_CTRL) begin
      mode_ctrl <= pwdata[ICU_CTRL_W-1:0]; // [R1] [R2]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask <= '0;
      pin_ctrl <= ICU_PIN_RESET;
    end else if (wr_en) begin
      if (idx == ICU_IDX_MASK) mask <= wdat_st;
      if (idx == ICU_IDX_PIN_CTRL) pin_ctrl <= pwdata[ICU_PIN_W-1:0];
    end
  end

  // Pin location and direction; an output pin is read back as its drive
  logic sel_dir;
  logic sel_pin;
  assign sel_dir = unit_pin_location_select_i ?
    pin_ctrl[ICU_PIN_DIR3] : pin_ctrl[ICU_PIN_DIR0]; // [R10]
  assign sel_pin = unit_pin_location_select_i ?
    port_b3_pin_i : port_b0_pin_i; // [R10]
  // Direction bit high means input
  assign unit_pin_oe_o = ~sel_dir;
  assign unit_pin_o = pin_ctrl[ICU_PIN_DATA];
  assign pin_level = sel_dir ? sel_pin : pin_ctrl[ICU_PIN_DATA]; // [R9]

  icu_edge_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin_level),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Prescaler: cleared only when off or outside capture, so a direct
  // switch between capture settings keeps a partly advanced count.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc <= '0;
    end else if (!is_capture(mode)) begin
      presc <= '0; // [R3] [R13]
    end else if (rise && (mode == ICU_M_CAP_RISE4 ||
                          mode == ICU_M_CAP_RISE16)) begin
      if ((mode == ICU_M_CAP_RISE4 && presc[1:0] == ICU_DIV4_LAST[1:0]) ||
          (mode == ICU_M_CAP_RISE16 && presc == ICU_DIV16_LAST)) begin
        presc <= '0; // [R18]
      end else begin
        presc <= presc + 4'h1; // [R14] [R18]
      end
    end
  end

  always_comb begin
    case (mode)
      ICU_M_CAP_FALL: cap_event = fall; // [R5]
      ICU_M_CAP_RISE: cap_event = rise; // [R5]
      ICU_M_CAP_RISE4:
        cap_event = rise && presc[1:0] == ICU_DIV4_LAST[1:0]; // [R5]
      ICU_M_CAP_RISE16:
        cap_event = rise && presc == ICU_DIV16_LAST; // [R5]
      default: cap_event = 1'b0;
    endcase
  end

  // Latest capture always wins; no lock against unread values
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_value_pair <= '0;
    end else if (cap_event) begin
      capture_value_pair <= first_timer_count_i; // [R4] [R7]
    end else if (wr_en && !is_capture(mode)) begin
      if (idx == ICU_IDX_CAP_LOW) capture_value_pair[7:0] <= pwdata[7:0];
      if (idx == ICU_IDX_CAP_HIGH) capture_value_pair[15:8] <= pwdata[7:0];
    end
  end

  // Compare match against the held value, edge of equality only
  logic match_q;
  wire logic match_now = is_compare(mode) &&
    first_timer_count_i == capture_value_pair;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_now;
    end
  end
  assign cmp_match = match_now & ~match_q; // [R16]

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_timer_reset_o <= 1'b0;
      convert_start_o <= 1'b0;
    end else begin
      // Only a pulse; the timer's overflow flag is not touched here
      first_timer_reset_o <= cmp_match && mode == ICU_M_CMP_SPECIAL; // [R17]
      convert_start_o <= cmp_match && mode == ICU_M_CMP_SPECIAL; // [R17]
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  logic [ICU_ST_W-1:0] set_st;
  assign set_st[ICU_ST_CAPTURE] = cap_event;
  assign set_st[ICU_ST_COMPARE] = cmp_match;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
    end else begin
      if (wr_en && idx == ICU_IDX_STATUS) begin
        status <= (status & ~wdat_st) | set_st; // [R6]
      end else begin
        status <= status | set_st; // [R6] [R16]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end
endmodule
`default_nettype wire

// ### logic/icu_pkg.sv
// Package for the input capture unit: register map, fields, modes.
// Assumes a 32-bit APB slave with word-aligned registers.
package icu_pkg;
  localparam int ICU_AW = 8;
  // Printed offset 0x17 is not a multiple of four: kept as an index
  localparam logic [7:0] ICU_IDX_MODE_CTRL = 8'h17;
  localparam logic [7:0] ICU_IDX_CAP_LOW = 8'h15;
  localparam logic [7:0] ICU_IDX_CAP_HIGH = 8'h16;
  localparam logic [7:0] ICU_IDX_STATUS = 8'h20;
  localparam logic [7:0] ICU_IDX_MASK = 8'h21;
  localparam logic [7:0] ICU_IDX_PIN_CTRL = 8'h22;
  localparam logic [5:0] ICU_MODE_CTRL_RESET = 6'h00;
  localparam int ICU_MODE_LSB = 0;
  localparam int ICU_MODE_MSB = 3;
  localparam int ICU_DUTY_LSB = 4;
  localparam int ICU_DUTY_MSB = 5;
  localparam int ICU_CTRL_W = 6;
  localparam int ICU_ST_CAPTURE = 0;
  localparam int ICU_ST_COMPARE = 1;
  localparam int ICU_ST_W = 2;
  localparam int ICU_PIN_DIR0 = 0;
  localparam int ICU_PIN_DIR3 = 1;
  localparam int ICU_PIN_DATA = 2;
  localparam int ICU_PIN_W = 3;
  localparam logic [2:0] ICU_PIN_RESET = 3'h3;
  localparam logic [3:0] ICU_M_OFF = 4'h0;
  localparam logic [3:0] ICU_M_CAP_FALL = 4'h4;
  localparam logic [3:0] ICU_M_CAP_RISE = 4'h5;
  localparam logic [3:0] ICU_M_CAP_RISE4 = 4'h6;
  localparam logic [3:0] ICU_M_CAP_RISE16 = 4'h7;
  localparam logic [3:0] ICU_M_CMP_SET = 4'h8;
  localparam logic [3:0] ICU_M_CMP_CLR = 4'h9;
  localparam logic [3:0] ICU_M_CMP_SWI = 4'hA;
  localparam logic [3:0] ICU_M_CMP_SPECIAL = 4'hB;
  localparam logic [3:0] ICU_DIV4_LAST = 4'h3;
  localparam logic [3:0] ICU_DIV16_LAST = 4'hF;
  typedef enum logic [1:0] {
    ICU_EDGE_NONE_TYPE_UNUSED_HELPER
  } icu_unused_type;
endpackage

// ### logic/icu_edge_sync.sv
// Two-flop synchroniser with edge detection for the capture pin.
// Assumes pin_i is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module icu_edge_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic last;
  logic [2:0] fill;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  // Hides the false edge while the chain fills after reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end

  assign rise_o = sync & ~last & fill[2];
  assign fall_o = ~sync & last & fill[2];
endmodule
`default_nettype wire

// ### sim/icu_pin_src.sv
// Signal source on the two candidate capture pins.
// Assumes the unit drives only the selected pin when its enable is high.
`timescale 1ns/1ps
`default_nettype none
module icu_pin_src (
  input wire logic src0_i,
  input wire logic src3_i,
  input wire logic loc_i,
  input wire logic oe_i,
  input wire logic out_i,
  output logic b0_o,
  output logic b3_o
);
  // Driven latch wins over the source
  assign b0_o = (oe_i && !loc_i) ? out_i : src0_i;
  assign b3_o = (oe_i && loc_i) ? out_i : src3_i;
endmodule
`default_nettype wire

// ### sim/icu_top_asserts.sv
// Port checker for icu_top.
// Assumes one clock domain and APB writes shadowed here.
`timescale 1ns/1ps
`default_nettype none
module icu_top_asserts
  import icu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_timer_reset_o,
  input wire logic convert_start_o,
  input wire logic unit_pin_oe_o,
  input wire logic irq_o
);
  logic acc;
  logic mapped;
  logic [5:0] ctrl_sh;
  logic [1:0] mask_sh;
  assign acc = psel && penable;
  assign mapped = paddr == 32'h54 || paddr == 32'h58 || paddr == 32'h5C
    || paddr == 32'h80 || paddr == 32'h84 || paddr == 32'h88;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_sh <= 6'h00;
    end else if (acc && pwrite && paddr == 32'h5C) begin
      ctrl_sh <= pwdata[5:0];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_sh <= 2'h0;
    end else if (acc && pwrite && paddr == 32'h84) begin
      mask_sh <= pwdata[1:0];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_ctrl;
    acc && !pwrite && paddr == 32'h5C;
  endsequence
  pready_high_a: assert property (pready) else $error("pready low");
  ctrl_read_a: assert property (rd_ctrl |=> prdata == {26'h0, $past(ctrl_sh)})
    else $error("control readback wrong");
  unmapped_err_a: assert property (acc |-> pslverr == !mapped)
    else $error("slave error wrong");
  reset_pulse_a: assert property (first_timer_reset_o |=> !first_timer_reset_o)
    else $error("timer reset not one cycle");
  conv_pulse_a: assert property ($rose(convert_start_o) |-> ##1 !convert_start_o)
    else $error("conversion start not one cycle");
  special_only_a: assert property (first_timer_reset_o |-> ctrl_sh[3:0] == 4'hB)
    else $error("timer reset outside special mode");
  conv_mode_a: assert property (convert_start_o |-> ctrl_sh[3:0] == 4'hB)
    else $error("conversion start outside special mode");
  irq_mask_a: assert property (irq_o |-> $past(mask_sh) != 2'h0)
    else $error("interrupt while masked");
  reset_quiet_a: assert property ($rose(rst_n_i) |-> !irq_o && !unit_pin_oe_o)
    else $error("outputs active after reset");
endmodule
bind icu_top icu_top_asserts icu_top_asserts_i (.sys_clk_i, .rst_n_i, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .first_timer_reset_o, .convert_start_o, .unit_pin_oe_o, .irq_o);
`default_nettype wire

// ### sim/icu_top_bench.sv
// Self-checking bench for icu_top over APB.
// Assumes prdata stands at the access edge.
`timescale 1ns/1ps
`default_nettype none
module icu_top_bench
  import icu_pkg::*;
;
  logic sys_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic loc = 0, s0 = 1, s3 = 1, err_seen;
  int ftr_cnt = 0, cnv_cnt = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdata;
  logic pready, pslverr, b0, b3, pin_o, oe, ftr, cnv, irq;
  logic [15:0] tmr = 0;
  int err_count = 0, compares = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (ftr === 1'b1) ftr_cnt++;
  always @(posedge sys_clk_i) if (cnv === 1'b1) cnv_cnt++;
  icu_top icu_top_i (.sys_clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .first_timer_count_i(tmr),
    .unit_pin_location_select_i(loc), .port_b0_pin_i(b0), .port_b3_pin_i(b3),
    .unit_pin_o(pin_o), .unit_pin_oe_o(oe), .first_timer_reset_o(ftr),
    .convert_start_o(cnv), .irq_o(irq));
  icu_pin_src icu_pin_src_i (.src0_i(s0), .src3_i(s3), .loc_i(loc),
    .oe_i(oe), .out_i(pin_o), .b0_o(b0), .b3_o(b3));
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {22'h0, i, 2'b00};
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    err_seen = pslverr;
    rdata = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), rdata, e);
  endtask
  task automatic lvl(input logic v);
    @(posedge sys_clk_i);
    if (loc) s3 <= v; else s0 <= v;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task automatic rise(input int n);
    repeat (n) begin
      lvl(1'b0);
      lvl(1'b1);
    end
  endtask
  task automatic mode(input logic [3:0] m);
    wr(ICU_IDX_MODE_CTRL, 32'h0);
    wr(ICU_IDX_MODE_CTRL, {28'h0, m});
    wr(ICU_IDX_STATUS, 32'h3);
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk_i);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(ICU_IDX_MODE_CTRL, 32'h0);
    rd(ICU_IDX_PIN_CTRL, 32'h3);
    wr(ICU_IDX_MODE_CTRL, 32'hFFFFFFFF);
    rd(ICU_IDX_MODE_CTRL, 32'h3F);
    xfer(1'b0, 8'h30, 32'h0);
    chk("slverr", {31'h0, err_seen}, 32'h1);
    @(posedge sys_clk_i) tmr <= 16'hA5C3;
    mode(ICU_M_CAP_RISE);
    rise(1);
    @(posedge sys_clk_i) tmr <= 16'h1234;
    rise(1);
    rd(ICU_IDX_CAP_LOW, 32'h34);
    rd(ICU_IDX_CAP_HIGH, 32'h12);
    rd(ICU_IDX_STATUS, 32'h1);
    wr(ICU_IDX_STATUS, 32'h1);
    rd(ICU_IDX_STATUS, 32'h0);
    mode(ICU_M_CAP_FALL);
    @(posedge sys_clk_i) tmr <= 16'h0F0F;
    lvl(1'b0);
    @(posedge sys_clk_i) tmr <= 16'h7777;
    lvl(1'b1);
    rd(ICU_IDX_CAP_LOW, 32'h0F);
    for (int k = 0; k < 2; k++) begin
      mode(k ? ICU_M_CAP_RISE16 : ICU_M_CAP_RISE4);
      rise(k ? 15 : 3);
      rd(ICU_IDX_STATUS, 32'h0);
      rise(1);
      rd(ICU_IDX_STATUS, 32'h1);
    end
    mode(ICU_M_CAP_RISE4);
    rise(2);
    wr(ICU_IDX_MODE_CTRL, {28'h0, ICU_M_CAP_RISE16});
    rise(13);
    rd(ICU_IDX_STATUS, 32'h0);
    rise(1);
    rd(ICU_IDX_STATUS, 32'h1);
    mode(ICU_M_CAP_RISE4);
    rise(2);
    mode(ICU_M_CAP_RISE4);
    rise(3);
    rd(ICU_IDX_STATUS, 32'h0);
    rise(1);
    wr(ICU_IDX_MASK, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(ICU_IDX_MASK, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    @(posedge sys_clk_i) loc <= 1'b1;
    mode(ICU_M_CAP_RISE);
    rise(1);
    rd(ICU_IDX_STATUS, 32'h1);
    @(posedge sys_clk_i) loc <= 1'b0;
    wr(ICU_IDX_PIN_CTRL, 32'h2);
    mode(ICU_M_CAP_RISE);
    wr(ICU_IDX_PIN_CTRL, 32'h6);
    repeat (8) @(posedge sys_clk_i);
    chk("pin drive", {30'h0, oe, pin_o}, 32'h3);
    rd(ICU_IDX_STATUS, 32'h1);
    wr(ICU_IDX_PIN_CTRL, 32'h3);
    wr(ICU_IDX_MODE_CTRL, 32'h0);
    wr(ICU_IDX_CAP_LOW, 32'h10);
    wr(ICU_IDX_CAP_HIGH, 32'h0);
    @(posedge sys_clk_i) tmr <= 16'h0;
    mode(ICU_M_CMP_SPECIAL);
    @(posedge sys_clk_i) tmr <= 16'h10;
    repeat (4) @(posedge sys_clk_i);
    chk("timer reset", ftr_cnt, 32'h1);
    chk("conversion", cnv_cnt, 32'h1);
    @(posedge sys_clk_i) tmr <= 16'h0;
    mode(ICU_M_CMP_SWI);
    @(posedge sys_clk_i) tmr <= 16'h10;
    repeat (4) @(posedge sys_clk_i);
    rd(ICU_IDX_STATUS, 32'h2);
    chk("timer reset", ftr_cnt, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
